//--- hw/host_port_device.sv
// Device end: decodes host cycles into register and FIFO word accesses.
// Assumes strobes are synchronous to clk_sys and held STROBE_CYC cycles.
`timescale 1ns/1ns
`default_nettype none
module host_port_device (
    input wire logic clk_sys, // 50 MHz clock
    input wire logic rst_b, // async reset, active low
    host_port_if.device port, // host-facing pins
    input wire logic sleepReq, // enter reduced-power state
    input wire logic wakeEvent, // wake event detected
    input wire logic [host_port_pkg::IRQ_SRC_W-1:0] irqSources, // interrupt causes
    input wire logic [host_port_pkg::WORD_W-1:0] rxWord, // word to give host
    output logic rxPop, // rx word consumed
    output logic [host_port_pkg::WORD_W-1:0] txWord, // assembled word
    output logic txPush, // tx word valid pulse
    output logic [host_port_pkg::FIFO_ADDR_W-1:0] fifoAddr, // FIFO port address
    output logic asleep // in reduced-power state
);
    import host_port_pkg::*;

    logic [15:0] irqCfg_r, irqCfg_nxt;
    logic asleep_r, asleep_nxt;
    logic readSeen_r, readSeen_nxt;
    logic rdPrev_r, wrPrev_r;
    logic hiHalf_r, hiHalf_nxt;
    logic [15:0] txLow_r, txLow_nxt;
    logic [31:0] txWord_r, txWord_nxt;
    logic txPush_r, txPush_nxt, rxPop_r, rxPop_nxt;
    logic [1:0] fifoAddr_r, fifoAddr_nxt;
    logic [15:0] dout_r, dout_nxt;
    logic oeN_r, oeN_nxt, irq_r, irq_nxt, irqOe_r, irqOe_nxt, wake_r, wake_nxt;
    logic rdAct, wrAct, rdStart, wrEnd, irqAct;
    logic [15:0] wrData_r, wrData_nxt;
    logic [6:0] wrAddr_r, wrAddr_nxt;
    logic wrFifo_r, wrFifo_nxt;

    // FIFO slot from the low address bits; upper bits do not matter
    function automatic logic [FIFO_ADDR_W-1:0] fifoSlot(input logic [ADDR_W-1:0] a);
        return a[FIFO_ADDR_W-1:0];
    endfunction : fifoSlot

    // Register read decode; unmapped words read as zero
    function automatic logic [DATA_W-1:0] regRead(input logic [ADDR_W-1:0] a,
                                                  input logic [DATA_W-1:0] cfg,
                                                  input logic sleeping);
        logic [DATA_W-1:0] v;
        v = 16'h0000;
        unique case (a)
            ADDR_PROBE: v = PROBE_VALUE;
            ADDR_IRQ_CFG: v = cfg;
            ADDR_PWR_CTL: v = {15'h0000, sleeping};
            default: v = 16'h0000;
        endcase
        return v;
    endfunction : regRead

    // Pins and halves are fixed by the interface; refuse other shapes
    if (ADDR_W != 7) begin : g_bad_addr
        $error("word address must be seven bits");
    end
    if (FIFO_ADDR_W < 1 || FIFO_ADDR_W > 2) begin : g_bad_slot
        $error("FIFO slot width must be one or two bits");
    end
    if (WORD_W != 2 * DATA_W) begin : g_bad_word
        $error("internal word must be two bus halves");
    end

    always_comb begin
        rdAct = !port.chipSelectN && !port.readStrobeN;
        wrAct = !port.chipSelectN && !port.writeStrobeN;
        rdStart = rdAct && !rdPrev_r;
        wrEnd = !wrAct && wrPrev_r;
        irqAct = |(irqSources & irqCfg_r[IRQ_EN_LSB +: IRQ_SRC_W]);
        irqCfg_nxt = irqCfg_r;
        asleep_nxt = asleep_r;
        readSeen_nxt = readSeen_r;
        hiHalf_nxt = hiHalf_r;
        txLow_nxt = txLow_r;
        txWord_nxt = txWord_r;
        txPush_nxt = 1'b0;
        rxPop_nxt = 1'b0;
        fifoAddr_nxt = fifoAddr_r;
        dout_nxt = dout_r;
        wrData_nxt = wrData_r;
        wrAddr_nxt = wrAddr_r;
        wrFifo_nxt = wrFifo_r;
        // Host lets go of the bus with the strobe, so keep the last strobe cycle
        if (wrAct) begin
            wrData_nxt = port.dataIn;
            wrAddr_nxt = port.addr;
            wrFifo_nxt = port.fifoSel;
        end

        if (sleepReq && !asleep_r) begin
            asleep_nxt = 1'b1;
            readSeen_nxt = 1'b0;
        end
        if (asleep_r && wrAct) begin
            asleep_nxt = 1'b0;
            readSeen_nxt = 1'b0;
        end
        // Read data is fetched once, on the first selected strobe cycle
        if (rdStart && !asleep_r) begin
            readSeen_nxt = 1'b1;
            if (port.fifoSel) begin
                fifoAddr_nxt = fifoSlot(port.addr);
                dout_nxt = port.addr[0] ? rxWord[31:16] : rxWord[15:0];
                rxPop_nxt = port.addr[0];
            end else begin
                dout_nxt = regRead(port.addr, irqCfg_r, asleep_r);
            end
        end
        // Writes commit at strobe release from the values latched above
        if (wrEnd && readSeen_r && !asleep_r) begin
            if (wrFifo_r) begin
                fifoAddr_nxt = fifoSlot(wrAddr_r);
                if (!hiHalf_r) begin
                    txLow_nxt = wrData_r;
                    hiHalf_nxt = 1'b1;
                end else begin
                    txWord_nxt = {wrData_r, txLow_r};
                    txPush_nxt = 1'b1;
                    hiHalf_nxt = 1'b0;
                end
            end else if (wrAddr_r == ADDR_IRQ_CFG) begin
                irqCfg_nxt = wrData_r;
            end
        end

        // Bus trails the strobe by a cycle; the host gap keeps it clear
        oeN_nxt = !rdAct;
        // Open drain only ever pulls low, so the level stays at zero
        irq_nxt = irqCfg_r[IRQ_PP_BIT] ? (irqAct ~^ irqCfg_r[IRQ_POL_BIT]) : 1'b0;
        irqOe_nxt = irqCfg_r[IRQ_PP_BIT] ? 1'b0 : !irqAct;
        wake_nxt = wakeEvent && asleep_r;
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            irqCfg_r <= 16'h0000;
            asleep_r <= 1'b0;
            readSeen_r <= 1'b0;
            rdPrev_r <= 1'b0;
            wrPrev_r <= 1'b0;
            hiHalf_r <= 1'b0;
            txLow_r <= 16'h0000;
            txWord_r <= 32'h0000_0000;
            txPush_r <= 1'b0;
            rxPop_r <= 1'b0;
            fifoAddr_r <= 2'h0;
            dout_r <= 16'h0000;
            oeN_r <= 1'b1;
            irq_r <= 1'b0;
            irqOe_r <= 1'b1;
            wake_r <= 1'b0;
            wrData_r <= 16'h0000;
            wrAddr_r <= 7'h00;
            wrFifo_r <= 1'b0;
        end else begin
            irqCfg_r <= irqCfg_nxt;
            asleep_r <= asleep_nxt;
            readSeen_r <= readSeen_nxt;
            rdPrev_r <= rdAct;
            wrPrev_r <= wrAct;
            hiHalf_r <= hiHalf_nxt;
            txLow_r <= txLow_nxt;
            txWord_r <= txWord_nxt;
            txPush_r <= txPush_nxt;
            rxPop_r <= rxPop_nxt;
            fifoAddr_r <= fifoAddr_nxt;
            dout_r <= dout_nxt;
            oeN_r <= oeN_nxt;
            irq_r <= irq_nxt;
            irqOe_r <= irqOe_nxt;
            wake_r <= wake_nxt;
            wrData_r <= wrData_nxt;
            wrAddr_r <= wrAddr_nxt;
            wrFifo_r <= wrFifo_nxt;
        end
    end

    // Read data lags strobe by one cycle; host samples late in strobe
    assign port.devDataOut = dout_r;
    assign port.devDataOeN = oeN_r;
    assign port.irqOut = irq_r;
    assign port.irqOeN = irqOe_r;
    assign port.wakeIndicatorOut = wake_r;
    assign rxPop = rxPop_r;
    assign txWord = txWord_r;
    assign txPush = txPush_r;
    assign fifoAddr = fifoAddr_r;
    assign asleep = asleep_r;
endmodule : host_port_device
`default_nettype wire

//--- hw/host_port_pkg.sv
// Shared constants for the SRAM-like host port: widths, address map, timing.
// Assumes both ends run from one 50 MHz clock.
package host_port_pkg;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 16;
    localparam int WORD_W = 32;
    localparam int FIFO_ADDR_W = 2;
    localparam logic [6:0] ADDR_PROBE = 7'h32;
    localparam logic [6:0] ADDR_IRQ_CFG = 7'h2c;
    localparam logic [6:0] ADDR_PWR_CTL = 7'h3e;
    localparam int IRQ_POL_BIT = 0;
    localparam int IRQ_PP_BIT = 1;
    localparam int IRQ_EN_LSB = 4;
    localparam int IRQ_SRC_W = 4;
    localparam logic [15:0] PROBE_VALUE = 16'h4321;
    localparam int CLK_MHZ = 50;
    localparam int STROBE_NS = 60;
    localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int GAP_CYC = 2;
endpackage : host_port_pkg

//--- hw/host_port_if.sv
// Interface joining host end and device end of the SRAM-like port.
// The bench resolves the data bus from the two enables.
`timescale 1ns/1ns
`default_nettype none
interface host_port_if;
    logic chipSelectN;
    logic readStrobeN;
    logic writeStrobeN;
    logic fifoSel;
    logic [6:0] addr;
    logic [15:0] hostDataOut;
    logic hostDataOeN;
    logic [15:0] devDataOut;
    logic devDataOeN;
    logic [15:0] dataIn;
    logic irqOut;
    logic irqOeN;
    logic wakeIndicatorOut;
    modport host (output chipSelectN, readStrobeN, writeStrobeN, fifoSel, addr,
                  hostDataOut, hostDataOeN, input dataIn, irqOut, irqOeN,
                  wakeIndicatorOut);
    modport device (input chipSelectN, readStrobeN, writeStrobeN, fifoSel, addr,
                    dataIn, output devDataOut, devDataOeN, irqOut, irqOeN,
                    wakeIndicatorOut);
endinterface : host_port_if
`default_nettype wire

//--- hw/host_port_host.sv
// Host end: turns single-word requests into timed strobe cycles.
// Assumes the device end samples on the same clk_sys.
`timescale 1ns/1ns
`default_nettype none
module host_port_host (
    input wire logic clk_sys, // 50 MHz clock
    input wire logic rst_b, // async reset, active low
    host_port_if.host port, // device-facing pins
    input wire logic reqValid, // start one access
    input wire logic reqWrite, // 1 write, 0 read
    input wire logic reqFifo, // drive FIFO select
    input wire logic [host_port_pkg::ADDR_W-1:0] reqAddr, // word address
    input wire logic [host_port_pkg::DATA_W-1:0] reqData, // write data
    output logic busy, // access in progress
    output logic rspValid, // read data pulse
    output logic [host_port_pkg::DATA_W-1:0] rspData // read data
);
    import host_port_pkg::*;

    typedef enum logic [1:0] {IDLE = 2'b00, STROBE = 2'b01, GAP = 2'b10} hstate_t;
    hstate_t st_r, st_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    logic cs_r, cs_nxt, rd_r, rd_nxt, wr_r, wr_nxt, fs_r, fs_nxt, oe_r, oe_nxt;
    logic [6:0] a_r, a_nxt;
    logic [15:0] d_r, d_nxt, rsp_r, rsp_nxt;
    logic rv_r, rv_nxt;
    logic busy_r, busy_nxt;

    // The 8-bit phase counter ends each phase on a count of one
    if (STROBE_CYC < 1 || STROBE_CYC > 255 || GAP_CYC < 1 || GAP_CYC > 255) begin : g_bad_count
        $error("strobe and gap counts must be 1 to 255");
    end

    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        cs_nxt = cs_r;
        rd_nxt = rd_r;
        wr_nxt = wr_r;
        fs_nxt = fs_r;
        oe_nxt = oe_r;
        a_nxt = a_r;
        d_nxt = d_r;
        rsp_nxt = rsp_r;
        rv_nxt = 1'b0;
        unique case (st_r)
            IDLE: begin
                if (reqValid) begin
                    st_nxt = STROBE;
                    cnt_nxt = 8'(STROBE_CYC);
                    cs_nxt = 1'b0;
                    rd_nxt = reqWrite;
                    wr_nxt = !reqWrite;
                    oe_nxt = !reqWrite;
                    fs_nxt = reqFifo;
                    a_nxt = reqAddr;
                    d_nxt = reqData;
                end
            end
            STROBE: begin
                cnt_nxt = cnt_r - 8'h01;
                if (cnt_r == 8'h01) begin
                    st_nxt = GAP;
                    cnt_nxt = 8'(GAP_CYC);
                    cs_nxt = 1'b1;
                    rd_nxt = 1'b1;
                    wr_nxt = 1'b1;
                    oe_nxt = 1'b1;
                    if (!rd_r) begin
                        rsp_nxt = port.dataIn;
                        rv_nxt = 1'b1;
                    end
                end
            end
            GAP: begin
                cnt_nxt = cnt_r - 8'h01;
                if (cnt_r == 8'h01) begin
                    st_nxt = IDLE;
                end
            end
            default: st_nxt = IDLE;
        endcase
        busy_nxt = (st_nxt != IDLE);
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= IDLE;
            cnt_r <= 8'h00;
            cs_r <= 1'b1;
            rd_r <= 1'b1;
            wr_r <= 1'b1;
            fs_r <= 1'b0;
            oe_r <= 1'b1;
            a_r <= 7'h00;
            d_r <= 16'h0000;
            rsp_r <= 16'h0000;
            rv_r <= 1'b0;
            busy_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            cs_r <= cs_nxt;
            rd_r <= rd_nxt;
            wr_r <= wr_nxt;
            fs_r <= fs_nxt;
            oe_r <= oe_nxt;
            a_r <= a_nxt;
            d_r <= d_nxt;
            rsp_r <= rsp_nxt;
            rv_r <= rv_nxt;
            busy_r <= busy_nxt;
        end
    end

    assign port.chipSelectN = cs_r;
    assign port.readStrobeN = rd_r;
    assign port.writeStrobeN = wr_r;
    assign port.fifoSel = fs_r;
    assign port.addr = a_r;
    assign port.hostDataOut = d_r;
    assign port.hostDataOeN = oe_r;
    assign busy = busy_r;
    assign rspValid = rv_r;
    assign rspData = rsp_r;
endmodule : host_port_host
`default_nettype wire

//--- verif/host_port_checker.sv
// Concurrent checks on the host port pins between the two ends.
// Assumes one clk_sys domain; instantiated beside the interface.
`timescale 1ns/1ns
`default_nettype none
module host_port_checker (
    input wire logic clk_sys, // system clock
    input wire logic rst_b, // async reset, active low
    input wire logic chipSelectN, // chip select
    input wire logic readStrobeN, // read strobe
    input wire logic writeStrobeN, // write strobe
    input wire logic [6:0] addr, // word address
    input wire logic hostDataOeN, // host bus enable
    input wire logic devDataOeN // device bus enable
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);
    a_drive_on_read: assert property (
        $fell(devDataOeN) |-> !chipSelectN && !readStrobeN)
        else $error("device drove bus outside a read");
    a_drive_window: assert property (
        !devDataOeN |-> $past(!chipSelectN && !readStrobeN))
        else $error("device drove bus without a selected read");
    a_no_contention: assert property (
        !(!devDataOeN && !hostDataOeN))
        else $error("both ends drive the bus");
    a_bus_release: assert property (
        $rose(readStrobeN) |-> ##[1:3] devDataOeN)
        else $error("device kept the bus after read");
    a_read_len: assert property (
        $fell(readStrobeN) |-> !readStrobeN [*3] ##1 readStrobeN)
        else $error("read strobe length wrong");
    a_write_len: assert property (
        $fell(writeStrobeN) |-> !writeStrobeN [*3] ##1 writeStrobeN)
        else $error("write strobe length wrong");
    a_write_data: assert property (
        !writeStrobeN |-> !hostDataOeN)
        else $error("write strobe without host data");
    a_strobe_select: assert property (
        !readStrobeN || !writeStrobeN |-> !chipSelectN)
        else $error("strobe without chip select");
    a_one_strobe: assert property (
        !(!readStrobeN && !writeStrobeN))
        else $error("read and write strobes together");
    a_addr_held: assert property (
        !chipSelectN && $past(!chipSelectN) |-> $stable(addr))
        else $error("address moved in a cycle");
endmodule : host_port_checker
`default_nettype wire

//--- verif/tb_sram_like_host_port.sv
// Bench joining host end and device end through the interface.
// Assumes the two ends share clk_sys; bus resolved here from enables.
`timescale 1ns/1ns
`default_nettype none
module tb_sram_like_host_port;
    import host_port_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic reqValid = 1'b0, reqWrite = 1'b0, reqFifo = 1'b0;
    logic [6:0] reqAddr = 7'h00;
    logic [15:0] reqData = 16'h0000, q, cfg;
    logic busy, rspValid, rxPop, txPush, asleep;
    logic [15:0] rspData;
    logic sleepReq = 1'b0, wakeEvent = 1'b0;
    logic [3:0] irqSources = 4'h0;
    logic [31:0] rxWord = 32'h0, txWord, lastTx, r, seed = 32'h7abd6fec;
    logic [1:0] fifoAddr;
    int failures = 0, samplesChecked = 0, cyc = 0, pushes = 0, pops = 0;
    host_port_if bus();
    // Undriven bus shows a changing pattern, never a stale value
    assign bus.dataIn = !bus.devDataOeN ? bus.devDataOut :
                        !bus.hostDataOeN ? bus.hostDataOut : cyc[15:0];
    host_port_host u_host_port_host (.clk_sys(clk_sys), .rst_b(rst_b), .port(bus),
        .reqValid(reqValid), .reqWrite(reqWrite), .reqFifo(reqFifo), .reqAddr(reqAddr),
        .reqData(reqData), .busy(busy), .rspValid(rspValid), .rspData(rspData));
    host_port_device u_host_port_device (.clk_sys(clk_sys), .rst_b(rst_b), .port(bus),
        .sleepReq(sleepReq), .wakeEvent(wakeEvent), .irqSources(irqSources),
        .rxWord(rxWord), .rxPop(rxPop), .txWord(txWord), .txPush(txPush),
        .fifoAddr(fifoAddr), .asleep(asleep));
    host_port_checker u_host_port_checker (.clk_sys(clk_sys), .rst_b(rst_b),
        .chipSelectN(bus.chipSelectN), .readStrobeN(bus.readStrobeN),
        .writeStrobeN(bus.writeStrobeN), .addr(bus.addr),
        .hostDataOeN(bus.hostDataOeN), .devDataOeN(bus.devDataOeN));
    always #10 clk_sys = ~clk_sys;
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    // Pin pair {level, enable_n} for a config word and pending causes
    function automatic logic [1:0] expIrq(input logic [15:0] c, input logic [3:0] s);
        logic act;
        act = |(s & c[IRQ_EN_LSB +: IRQ_SRC_W]);
        if (c[IRQ_PP_BIT]) return {act ~^ c[IRQ_POL_BIT], 1'b0};
        return {1'b0, !act};
    endfunction : expIrq
    task automatic summarize();
        $display("failures %0d samples_checked %0d", failures, samplesChecked);
        if (failures == 0 && samplesChecked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic acc(input logic w, f, input logic [6:0] a, input logic [15:0] d);
        int n;
        n = 0;
        // Marker so a missing read answer cannot pass a compare
        q = 16'hbad1;
        @(posedge clk_sys) #1;
        {reqValid, reqWrite, reqFifo, reqAddr, reqData} = {1'b1, w, f, a, d};
        @(posedge clk_sys) #1;
        reqValid = 1'b0;
        while (busy !== 1'b0 && n < 20) begin
            if (rspValid === 1'b1) q = rspData;
            @(posedge clk_sys) #1;
            n++;
        end
        if (n == 20) failures++;
    endtask : acc
    task automatic waitCyc(input int n);
        repeat (n) @(posedge clk_sys) #1;
    endtask : waitCyc
    always @(posedge clk_sys) begin
        cyc++;
        if (txPush === 1'b1) begin
            pushes++;
            lastTx = txWord;
        end
        if (rxPop === 1'b1) pops++;
        if (cyc == 5000) begin
            failures++;
            summarize();
        end
    end
    initial begin
        waitCyc(10);
        rst_b = 1'b1;
        acc(1'b1, 1'b0, ADDR_IRQ_CFG, 16'h00f3);
        acc(1'b0, 1'b0, ADDR_PROBE, 16'h0000);
        chk(q, PROBE_VALUE);
        acc(1'b0, 1'b0, ADDR_IRQ_CFG, 16'h0000);
        chk(q, 16'h0000);
        acc(1'b0, 1'b0, ADDR_PWR_CTL, 16'h0000);
        chk(q, 16'h0000);
        acc(1'b1, 1'b0, ADDR_IRQ_CFG, 16'h00f3);
        acc(1'b0, 1'b0, ADDR_IRQ_CFG, 16'h0000);
        chk(q, 16'h00f3);
        irqSources = 4'(xs()) | 4'h1;
        // Both push-pull polarities, open drain, then a random setting
        for (int i = 0; i < 4; i++) begin
            r = xs();
            cfg = (i < 3) ? 16'h00f3 - 16'(i) : {8'h00, r[7:4], 2'b00, r[1:0]};
            acc(1'b1, 1'b0, ADDR_IRQ_CFG, cfg);
            waitCyc(4);
            chk({bus.irqOut, bus.irqOeN}, expIrq(cfg, irqSources));
        end
        acc(1'b1, 1'b0, ADDR_IRQ_CFG, 16'h00f0);
        waitCyc(4);
        chk(bus.irqOeN, 1'b0);
        irqSources = 4'h0;
        waitCyc(4);
        chk(bus.irqOeN, 1'b1);
        for (int i = 0; i < 3; i++) begin
            r = xs();
            acc(1'b1, 1'b1, {r[20:16], 2'b00}, r[15:0]);
            acc(1'b1, 1'b1, {r[28:24], 2'b00}, r[31:16]);
            chk(lastTx, r);
            chk(pushes, i + 1);
        end
        rxWord = xs();
        acc(1'b0, 1'b1, {ADDR_PROBE[6:1], 1'b0}, 16'h0000);
        chk(q, rxWord[15:0]);
        acc(1'b0, 1'b1, {ADDR_PROBE[6:1], 1'b1}, 16'h0000);
        chk(q, rxWord[31:16]);
        chk(fifoAddr, {ADDR_PROBE[1], 1'b1});
        chk(pops, 1);
        sleepReq = 1'b1;
        waitCyc(3);
        sleepReq = 1'b0;
        wakeEvent = 1'b1;
        waitCyc(3);
        chk(asleep, 1'b1);
        chk(bus.wakeIndicatorOut, 1'b1);
        wakeEvent = 1'b0;
        acc(1'b0, 1'b0, ADDR_PROBE, 16'h0000);
        chk(asleep, 1'b1);
        acc(1'b1, 1'b0, ADDR_PROBE, PROBE_VALUE);
        chk(asleep, 1'b0);
        chk(bus.wakeIndicatorOut, 1'b0);
        acc(1'b1, 1'b0, ADDR_IRQ_CFG, 16'h0000);
        acc(1'b0, 1'b0, ADDR_PROBE, 16'h0000);
        acc(1'b0, 1'b0, ADDR_IRQ_CFG, 16'h0000);
        chk(q, 16'h00f0);
        summarize();
    end
endmodule : tb_sram_like_host_port
`default_nettype wire
